// >>> hdl/fail_out_pkg.sv
// constants and types for the fail output and safety input block
package fail_out_pkg;
	localparam int CLK_FREQ_HZ = 200_000_000;
	localparam int BLINK_FREQ_CHZ = 125;
	localparam int DIM_FREQ_HZ = 100;
	localparam int DIM_DUTY_PCT = 20;
	localparam int FSI_WINDOW_US = 240;
	localparam int FSI_FILTER_NS = 1500;
	localparam int BLINK_PERIOD_CYC = (CLK_FREQ_HZ / BLINK_FREQ_CHZ) * 100;
	localparam int DIM_PERIOD_CYC = CLK_FREQ_HZ / DIM_FREQ_HZ;
	localparam int DIM_ON_CYC = DIM_PERIOD_CYC * DIM_DUTY_PCT / 100;
	localparam int FSI_WINDOW_CYC = (CLK_FREQ_HZ / 1_000_000) * FSI_WINDOW_US;
	localparam int FSI_FILTER_CYC = FSI_FILTER_NS / 5;
	localparam logic RESET_SAFETY_DISABLE = 1'b0;

	typedef enum logic [2:0] {
		MODE_INIT,
		MODE_NORMAL,
		MODE_STOP,
		MODE_SLEEP,
		MODE_RESTART,
		MODE_FAILSAFE
	} sbc_mode_type;

	typedef struct packed {
		logic watchdog_failure_flag_event;
		logic thermal_shutdown_stage2;
		logic main_supply_short;
		logic reset_output_clamped;
	} fail_cause_type;

	typedef struct packed {
		logic fail_outputs_active_flag;
		logic watchdog_failure_flag;
		logic safety_input_failure_flag;
	} device_status_type;

	typedef struct packed {
		logic watchdog_failure_flag_count_select;
		logic safety_input_disable;
	} hardware_control_type;

	typedef struct packed {
		logic clr_fail_outputs_active;
		logic clr_watchdog_failure;
		logic clr_safety_input_failure;
	} status_clear_type;

	typedef struct packed {
		logic static_out;
		logic blink_out;
		logic dim_out;
	} pin_group_type;
endpackage

// >>> hdl/fail_output_and_safety_input.sv
// fail output driver and safety heartbeat input supervisor
// Contract
// RULE1 - any failure activates outputs, sets active flag
// RULE2 - causes: watchdog, thermal, supply short, clamp
// RULE3 - select bit picks one or two watchdog failures
// RULE4 - release needs no failure and flag cleared
// RULE5 - watchdog activation holds until flag cleared after trigger
// RULE6 - activation also for non fail-safe failures
// RULE7 - three outputs switch on together
// RULE8 - static output low throughout activation
// RULE9 - blink output 1.25 Hz, half duty
// RULE10 - dim output 100 Hz, one fifth on
// RULE11 - pull-ups per mode and disable bit
// RULE12 - blink pin doubles as heartbeat input
// RULE13 - rising edge needed within each window
// RULE14 - supervision on after reset, disable bit stops
// RULE15 - missed window sets flag, drives static, dim
// RULE16 - safety failure changes no mode, reset, interrupt
// RULE17 - safety flag clears only after new edge
// RULE18 - supervision only in normal mode
// RULE19 - counters generate periods, window restarts on edge
`timescale 1ns/10ps
module fail_output_and_safety_input #(
	parameter int BLINK_PERIOD = fail_out_pkg::BLINK_PERIOD_CYC,
	parameter int DIM_PERIOD   = fail_out_pkg::DIM_PERIOD_CYC,
	parameter int DIM_ON       = fail_out_pkg::DIM_ON_CYC,
	parameter int FSI_WINDOW   = fail_out_pkg::FSI_WINDOW_CYC
) (
	// clock and reset
	input  wire logic                               mclk_in,
	input  wire logic                               nrst_in,
	// device state and failure sources
	input  wire fail_out_pkg::sbc_mode_type         sbc_mode_in,
	input  wire fail_out_pkg::fail_cause_type       fail_cause_in,
	input  wire logic                               wd_trigger_ok_in,
	// control bits and status clears
	input  wire fail_out_pkg::hardware_control_type hardware_control_reg_in,
	input  wire fail_out_pkg::status_clear_type     status_clear_in,
	// pins, output enable low while pin pulled low
	input  wire logic                               blink_pin_in,
	output fail_out_pkg::pin_group_type             pin_out,
	output fail_out_pkg::pin_group_type             pin_oe_n_out,
	output fail_out_pkg::pin_group_type             pullup_en_out,
	// status
	output fail_out_pkg::device_status_type         device_status_reg_out,
	output logic                                    fail_active_out
);
	import fail_out_pkg::*;

	localparam int BW = $clog2(BLINK_PERIOD + 1);
	localparam int DW = $clog2(DIM_PERIOD + 1);
	localparam int WW = $clog2(FSI_WINDOW + 1);

	logic          fail_outputs_active_flag;
	logic          watchdog_failure_flag;
	logic          safety_input_failure_flag;
	logic          watchdog_failure_flag_seen;
	logic          wd_trig_since_fail;
	logic          fail_active;
	logic          safety_active;
	logic [BW-1:0] blink_cnt;
	logic [DW-1:0] dim_cnt;
	logic [WW-1:0] win_cnt;
	logic          blink_phase;
	logic          dim_phase;
	logic          hb_meta;
	logic          hb_sync;
	logic          hb_prev;
	logic          hb_edge;
	logic          edge_since_fail;
	logic          supervise;
	logic          any_fail_event;
	logic          cond_present;
	logic          next_fail_active;

	// with select bit set only a second watchdog failure counts
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			watchdog_failure_flag_seen <= 1'b0;
		end else if (wd_trigger_ok_in) begin
			watchdog_failure_flag_seen <= 1'b0;
		end else if (fail_cause_in.watchdog_failure_flag_event) begin
			watchdog_failure_flag_seen <= 1'b1;
		end
	end

	logic watchdog_failure_flag_trip;
	assign watchdog_failure_flag_trip = fail_cause_in.watchdog_failure_flag_event &&
		(!hardware_control_reg_in.watchdog_failure_flag_count_select || watchdog_failure_flag_seen); // [RULE3]

	assign any_fail_event = watchdog_failure_flag_trip || fail_cause_in.thermal_shutdown_stage2 ||
		fail_cause_in.main_supply_short || fail_cause_in.reset_output_clamped; // [RULE2] [RULE6]
	assign cond_present = fail_cause_in.thermal_shutdown_stage2 ||
		fail_cause_in.main_supply_short || fail_cause_in.reset_output_clamped;

	// watchdog failure flag; set wins over clear, clear only after good trigger
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			watchdog_failure_flag <= 1'b0;
		end else if (watchdog_failure_flag_trip) begin
			watchdog_failure_flag <= 1'b1;
		end else if (status_clear_in.clr_watchdog_failure && wd_trig_since_fail) begin
			watchdog_failure_flag <= 1'b0; // [RULE5]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			wd_trig_since_fail <= 1'b0;
		end else if (watchdog_failure_flag_trip) begin
			wd_trig_since_fail <= 1'b0;
		end else if (wd_trigger_ok_in) begin
			wd_trig_since_fail <= 1'b1;
		end
	end

	// active flag: set wins over clear
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			fail_outputs_active_flag <= 1'b0;
		end else if (any_fail_event) begin
			fail_outputs_active_flag <= 1'b1; // [RULE1]
		end else if (status_clear_in.clr_fail_outputs_active) begin
			fail_outputs_active_flag <= 1'b0;
		end
	end

	always_comb begin
		next_fail_active = fail_active;
		if (any_fail_event) begin
			next_fail_active = 1'b1; // [RULE1]
		end else if (!cond_present && !fail_outputs_active_flag && !watchdog_failure_flag) begin
			next_fail_active = 1'b0; // [RULE4] [RULE5]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			fail_active <= 1'b0;
		end else begin
			fail_active <= next_fail_active;
		end
	end

	// heartbeat synchroniser and edge detect
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			hb_meta <= 1'b1;
			hb_sync <= 1'b1;
			hb_prev <= 1'b1;
		end else begin
			hb_meta <= blink_pin_in; // [RULE12]
			hb_sync <= hb_meta;
			hb_prev <= hb_sync;
		end
	end
	assign hb_edge = hb_sync && !hb_prev;

	assign supervise = (sbc_mode_in == MODE_NORMAL) && !hardware_control_reg_in.safety_input_disable; // [RULE14] [RULE18]

	// window counter restarts on each rising edge
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			win_cnt <= '0;
		end else if (!supervise || hb_edge) begin
			win_cnt <= '0; // [RULE19] [RULE13]
		end else if (win_cnt != WW'(FSI_WINDOW - 1)) begin
			win_cnt <= win_cnt + WW'(1);
		end
	end

	logic window_miss;
	assign window_miss = supervise && !hb_edge && (win_cnt == WW'(FSI_WINDOW - 2));

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			edge_since_fail <= 1'b0;
		end else if (window_miss) begin
			edge_since_fail <= 1'b0;
		end else if (hb_edge) begin
			edge_since_fail <= 1'b1;
		end
	end

	// safety failure touches only its flag and two outputs
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			safety_input_failure_flag <= 1'b0;
		end else if (window_miss) begin
			safety_input_failure_flag <= 1'b1; // [RULE15] [RULE16]
		end else if (status_clear_in.clr_safety_input_failure && (edge_since_fail || hb_edge)) begin
			safety_input_failure_flag <= 1'b0; // [RULE17]
		end
	end
	assign safety_active = safety_input_failure_flag;

	// blink and dim pattern counters
	always_ff @(posedge mclk_in) begin
		if (!nrst_in || !fail_active) begin
			blink_cnt <= '0;
		end else if (blink_cnt == BW'(BLINK_PERIOD - 1)) begin
			blink_cnt <= '0;
		end else begin
			blink_cnt <= blink_cnt + BW'(1); // [RULE19]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in || !(fail_active || safety_active)) begin
			dim_cnt <= '0;
		end else if (dim_cnt == DW'(DIM_PERIOD - 1)) begin
			dim_cnt <= '0;
		end else begin
			dim_cnt <= dim_cnt + DW'(1); // [RULE19]
		end
	end

	assign blink_phase = blink_cnt < BW'(BLINK_PERIOD / 2); // [RULE9]
	assign dim_phase = dim_cnt < DW'(DIM_ON);              // [RULE10]

	// open-drain pins, oe low pulls pin low
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			pin_oe_n_out <= 3'b111;
		end else begin
			pin_oe_n_out.static_out <= !(next_fail_active || safety_active); // [RULE7] [RULE8] [RULE15]
			pin_oe_n_out.blink_out <= !(next_fail_active && blink_phase);    // [RULE7] [RULE9]
			pin_oe_n_out.dim_out <= !((next_fail_active || safety_active) && dim_phase); // [RULE10]
		end
	end
	assign pin_out = '0;

	always_comb begin
		pullup_en_out.static_out = (sbc_mode_in == MODE_INIT) || (sbc_mode_in == MODE_NORMAL);
		pullup_en_out.blink_out = pullup_en_out.static_out && !hardware_control_reg_in.safety_input_disable;
		pullup_en_out.dim_out = (sbc_mode_in == MODE_INIT); // [RULE11]
	end

	always_comb begin
		device_status_reg_out.fail_outputs_active_flag = fail_outputs_active_flag;
		device_status_reg_out.watchdog_failure_flag = watchdog_failure_flag;
		device_status_reg_out.safety_input_failure_flag = safety_input_failure_flag;
	end
	assign fail_active_out = fail_active;

	// checks
	property p_fail_sets_flag;
		@(posedge mclk_in) disable iff (!nrst_in)
		any_fail_event |=> fail_outputs_active_flag && fail_active;
	endproperty
	a_fail_sets_flag: assert property (p_fail_sets_flag) else $error("flag not set"); // [RULE1]

	property p_static_low;
		@(posedge mclk_in) disable iff (!nrst_in)
		fail_active |-> !pin_oe_n_out.static_out;
	endproperty
	a_static_low: assert property (p_static_low) else $error("static not low"); // [RULE8]

	property p_hold;
		@(posedge mclk_in) disable iff (!nrst_in)
		fail_active && fail_outputs_active_flag |=> fail_active;
	endproperty
	a_hold: assert property (p_hold) else $error("released early"); // [RULE4]

	property p_wd_hold;
		@(posedge mclk_in) disable iff (!nrst_in)
		watchdog_failure_flag && !wd_trig_since_fail |=> watchdog_failure_flag;
	endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("wd flag cleared early"); // [RULE5]

	property p_pullup;
		@(posedge mclk_in) disable iff (!nrst_in)
		sbc_mode_in == MODE_STOP |-> pullup_en_out == 3'b000;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pullup wrong"); // [RULE11]

	property p_no_sup;
		@(posedge mclk_in) disable iff (!nrst_in)
		sbc_mode_in != MODE_NORMAL |-> !window_miss;
	endproperty
	a_no_sup: assert property (p_no_sup) else $error("miss outside normal"); // [RULE18]

	property p_miss;
		@(posedge mclk_in) disable iff (!nrst_in)
		window_miss |=> safety_input_failure_flag ##1 !pin_oe_n_out.static_out;
	endproperty
	a_miss: assert property (p_miss) else $error("miss not flagged"); // [RULE15]

	property p_clear_edge;
		@(posedge mclk_in) disable iff (!nrst_in)
		$fell(safety_input_failure_flag) && $past(nrst_in) |-> $past(edge_since_fail) || $past(hb_edge);
	endproperty
	a_clear_edge: assert property (p_clear_edge) else $error("cleared w/o edge"); // [RULE17]

	property p_edge_restart;
		@(posedge mclk_in) disable iff (!nrst_in)
		hb_edge |=> win_cnt == '0;
	endproperty
	a_edge_restart: assert property (p_edge_restart) else $error("no window restart"); // [RULE19]

	property p_all_on;
		@(posedge mclk_in) disable iff (!nrst_in)
		$rose(fail_active) && !$past(fail_active, 2) && !$past(safety_active, 2) |-> pin_oe_n_out == 3'b000;
	endproperty
	a_all_on: assert property (p_all_on) else $error("outputs not together"); // [RULE7]

	property p_one_watchdog_failure_flag;
		@(posedge mclk_in) disable iff (!nrst_in)
		fail_cause_in.watchdog_failure_flag_event && hardware_control_reg_in.watchdog_failure_flag_count_select && !watchdog_failure_flag_seen &&
			!watchdog_failure_flag |=> !watchdog_failure_flag;
	endproperty
	a_one_watchdog_failure_flag: assert property (p_one_watchdog_failure_flag) else $error("first watchdog_failure_flag tripped"); // [RULE3]

	property p_cause_holds;
		@(posedge mclk_in) disable iff (!nrst_in)
		cond_present |=> fail_active && !pin_oe_n_out.static_out;
	endproperty
	a_cause_holds: assert property (p_cause_holds) else $error("cause not held"); // [RULE4]

	property p_release;
		@(posedge mclk_in) disable iff (!nrst_in)
		$fell(fail_active) && $past(nrst_in) |-> !$past(cond_present) &&
			!$past(fail_outputs_active_flag) && !$past(watchdog_failure_flag);
	endproperty
	a_release: assert property (p_release) else $error("release too soon"); // [RULE5]

	property p_idle_off;
		@(posedge mclk_in) disable iff (!nrst_in)
		!next_fail_active && !safety_active |=> pin_oe_n_out == 3'b111;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("pins not released"); // [RULE4]

	property p_init_pullup;
		@(posedge mclk_in) disable iff (!nrst_in)
		sbc_mode_in == MODE_INIT |-> pullup_en_out.static_out && pullup_en_out.dim_out;
	endproperty
	a_init_pullup: assert property (p_init_pullup) else $error("init pullup off"); // [RULE11]

	property p_safe_hold;
		@(posedge mclk_in) disable iff (!nrst_in)
		safety_input_failure_flag && !edge_since_fail && !hb_edge |=> safety_input_failure_flag;
	endproperty
	a_safe_hold: assert property (p_safe_hold) else $error("safety flag lost"); // [RULE17]

	property p_disable_holds;
		@(posedge mclk_in) disable iff (!nrst_in)
		hardware_control_reg_in.safety_input_disable |=> win_cnt == '0;
	endproperty
	a_disable_holds: assert property (p_disable_holds) else $error("window ran"); // [RULE14]

	property p_mode_holds;
		@(posedge mclk_in) disable iff (!nrst_in)
		sbc_mode_in != MODE_NORMAL |=> win_cnt == '0;
	endproperty
	a_mode_holds: assert property (p_mode_holds) else $error("window ran in mode"); // [RULE18]
endmodule

// >>> bench/heartbeat_model.sv
// heartbeat model of the microcontroller on the safety input
`timescale 1ns/10ps
module heartbeat_model #(
	parameter int PERIOD = 20
) (
	// clock and run control
	input  wire logic mclk_in,
	input  wire logic run_in,
	// heartbeat level
	output logic      hb_out
);
	int cnt;
	// one rising edge a period while running, steady high when stopped
	always_ff @(posedge mclk_in) begin
		if (!run_in) begin
			cnt <= 0;
			hb_out <= 1'b1;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			hb_out <= (cnt >= PERIOD / 2);
		end
	end
endmodule

// >>> bench/fail_output_and_safety_input_bench.sv
// bench for the fail output and safety input block
`timescale 1ns/10ps
module fail_output_and_safety_input_bench;
	import fail_out_pkg::*;
	logic                 mclk_in = 1'b0;
	logic                 nrst_in = 1'b0;
	sbc_mode_type         mode = MODE_INIT;
	fail_cause_type       cause = '0;
	logic                 trig = 1'b0;
	hardware_control_type ctrl = '0;
	status_clear_type     clr = '0;
	logic                 run = 1'b0;
	logic                 hb;
	logic                 pin_lvl;
	pin_group_type        pins;
	pin_group_type        oe;
	pin_group_type        pu;
	device_status_type    stat;
	logic                 act;
	int                   error_cnt = 0;
	int                   total_checks = 0;
	int                   s;
	int                   b;
	int                   d;
	// heartbeat line is wired-and with the blink pull-down
	assign pin_lvl = hb & oe.blink_out;
	initial forever #2.5 mclk_in = ~mclk_in;
	fail_output_and_safety_input #(.BLINK_PERIOD(200), .DIM_PERIOD(40), .DIM_ON(8),
		.FSI_WINDOW(50)) uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .sbc_mode_in(mode),
		.fail_cause_in(cause), .wd_trigger_ok_in(trig), .hardware_control_reg_in(ctrl),
		.status_clear_in(clr), .blink_pin_in(pin_lvl), .pin_out(pins), .pin_oe_n_out(oe),
		.pullup_en_out(pu), .device_status_reg_out(stat), .fail_active_out(act));
	heartbeat_model #(.PERIOD(20)) hbm (.mclk_in(mclk_in), .run_in(run), .hb_out(hb));
	task results();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task note(input logic ok, input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (!ok) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chk_pins(input pin_group_type g, input pin_group_type e);
		note(g === e, 32'(g), 32'(e));
	endtask
	task chk_stat(input device_status_type g, input device_status_type e);
		note(g === e, 32'(g), 32'(e));
	endtask
	task chk_cnt(input logic [31:0] g, input logic [31:0] e);
		note(g === e, g, e);
	endtask
	task cyc(input int k);
		repeat (k) @(negedge mclk_in);
	endtask
	task pulse_clr(input status_clear_type c);
		clr = c;
		cyc(1);
		clr = '0;
	endtask
	task pulse_cause(input fail_cause_type c);
		cause = c;
		cyc(1);
		cause = '0;
	endtask
	task wd_recover();
		trig = 1'b1;
		cyc(1);
		trig = 1'b0;
		pulse_clr(3'h6);
		cyc(4);
	endtask
	task count_low(input int k);
		s = 0;
		b = 0;
		d = 0;
		repeat (k) begin
			cyc(1);
			s += (oe.static_out === 1'b0);
			b += (oe.blink_out === 1'b0);
			d += (oe.dim_out === 1'b0);
		end
	endtask
	task wait_safety();
		int i;
		for (i = 0; i < 200 && stat.safety_input_failure_flag !== 1'b1; i++) cyc(1);
		if (i == 200) begin
			error_cnt++;
			results();
		end
	endtask
	task pu_case(input sbc_mode_type m, input logic dis, input pin_group_type e);
		mode = m;
		ctrl.safety_input_disable = dis;
		#1;
		chk_pins(pu, e);
		cyc(1);
	endtask
	initial begin
		cyc(20);
		nrst_in = 1'b1;
		cyc(1);
		chk_pins(oe, 3'h7);
		chk_stat(stat, 3'h0);
		cause.thermal_shutdown_stage2 = 1'b1;
		cyc(2);
		chk_stat(stat, 3'h4);
		chk_pins(oe, 3'h0);
		chk_pins(pins, 3'h0);
		chk_cnt(act, 1);
		count_low(200);
		chk_cnt(s, 200);
		chk_cnt(b, 100);
		chk_cnt(d, 40);
		pulse_clr(3'h4);
		cyc(3);
		chk_cnt(oe.static_out, 0);
		cause = '0;
		pulse_clr(3'h4);
		cyc(4);
		chk_pins(oe, 3'h7);
		chk_cnt(act, 0);
		pulse_cause(4'h8);
		cyc(1);
		chk_stat(stat, 3'h6);
		pulse_clr(3'h6);
		cyc(3);
		chk_cnt(oe.static_out, 0);
		chk_stat(stat, 3'h2);
		wd_recover();
		chk_pins(oe, 3'h7);
		ctrl.watchdog_failure_flag_count_select = 1'b1;
		pulse_cause(4'h8);
		cyc(3);
		chk_pins(oe, 3'h7);
		pulse_cause(4'h8);
		cyc(1);
		chk_stat(stat, 3'h6);
		wd_recover();
		ctrl = '0;
		for (int i = 0; i < 2; i++) begin
			pulse_cause(i ? 4'h1 : 4'h2);
			cyc(1);
			chk_stat(stat, 3'h4);
			pulse_clr(3'h4);
			cyc(4);
			chk_pins(oe, 3'h7);
		end
		mode = MODE_NORMAL;
		run = 1'b1;
		cyc(300);
		chk_stat(stat, 3'h0);
		run = 1'b0;
		wait_safety();
		chk_stat(stat, 3'h1);
		cyc(2);
		count_low(40);
		chk_cnt(s, 40);
		chk_cnt(d, 8);
		chk_cnt(b, 0);
		pulse_clr(3'h1);
		cyc(3);
		chk_stat(stat, 3'h1);
		run = 1'b1;
		cyc(40);
		pulse_clr(3'h1);
		cyc(3);
		chk_stat(stat, 3'h0);
		ctrl.safety_input_disable = 1'b1;
		run = 1'b0;
		cyc(150);
		chk_stat(stat, 3'h0);
		ctrl = '0;
		mode = MODE_STOP;
		cyc(150);
		chk_stat(stat, 3'h0);
		pu_case(MODE_INIT, 1'b0, 3'h7);
		pu_case(MODE_INIT, 1'b1, 3'h5);
		pu_case(MODE_NORMAL, 1'b0, 3'h6);
		pu_case(MODE_STOP, 1'b0, 3'h0);
		results();
	end
endmodule
